//--- rtl/mcp_pkg.sv
// Purpose: constants and types shared by the core power-state controller
// Assumes: 250 MHz core clock
// Notes:   long counts are top-level parameters, defaults derived here
package mcp_pkg;

  localparam int unsigned CLK_MHZ                 = 250;
  // reference power-up wait, microseconds
  localparam int unsigned REFERENCE_POWERUP_TIME_US = 4400;
  localparam int unsigned REFERENCE_READY_STATE_CYCLES_DEF        = REFERENCE_POWERUP_TIME_US * CLK_MHZ;
  // watchdog (sleep timeout), milliseconds
  localparam int unsigned SLEEP_TIMEOUT_MS        = 2000;
  localparam longint unsigned WDOG_CYCLES_DEF     = 64'(SLEEP_TIMEOUT_MS) * 64'(CLK_MHZ) * 64'd1000;
  localparam int unsigned CNT_W                   = 32;

  localparam logic [CNT_W-1:0] CNT_ZERO           = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE            = 32'h0000_0001;

  typedef enum logic [2:0] {
    MCP_SLEEP,
    MCP_STANDBY,
    MCP_REF_WAIT,
    MCP_REFERENCE_READY,
    MCP_MEASURE
  } mcp_state_t;

endpackage : mcp_pkg

//--- rtl/mcp_timer_if.sv
// Purpose: carrier between controller and its countdown timers
// Assumes: single clock domain
// Notes:   load restarts, expired is a level
`timescale 1ns/1ns
`default_nettype none
interface mcp_timer_if;
  logic load;
  logic hold_expired;
  logic expired;
  modport ctrl  (output load, output hold_expired, input expired);
  modport timer (input load, input hold_expired, output expired);
endinterface : mcp_timer_if
`default_nettype wire

//--- rtl/mcp_timer.sv
// Purpose: loadable countdown timer with expired flag
// Assumes: length at least one cycle
// Notes:   resets expired; hold_expired forces expiry
`timescale 1ns/1ns
`default_nettype none
module mcp_timer #(
  parameter logic [31:0] LENGTH = 32'h0000_0010
) (
  input  wire logic clock,
  input  wire logic rst_b,
  mcp_timer_if.timer tif
);
  import mcp_pkg::*;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  assign next_count = tif.hold_expired ? CNT_ZERO :
                      tif.load         ? LENGTH :
                      (count != CNT_ZERO) ? count - CNT_ONE : CNT_ZERO;
  assign tif.expired = (count == CNT_ZERO);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) count <= CNT_ZERO;
    else count <= next_count;
  end
endmodule : mcp_timer
`default_nettype wire

//--- rtl/mcp_core.sv
// Purpose: core operating-state controller of a battery monitor
// Assumes: command strobes are one-cycle pulses, synchronous to clock
// Notes:   serial-link states live elsewhere; only wake and command pulses enter here
// Operation
// - sleep: reference, converters off; regulator drive 0
// - sleep to standby on serial wake-up
// - standby: analog off, regulator driven on
// - standby held while any timer runs
// - conversion or keep-on write of 1: wait, then advance
// - both timers expired: standby returns to sleep
// - discharge timer disabled: watchdog alone decides
// - reference-ready: reference on, converters off
// - reference-ready to measure on conversion command
// - keep-on cleared: reference-ready back to standby
// - watchdog clear with discharge expired: sleep
// - measure: reference and converters powered
// - done: reference-ready if keep-on, else standby
// - commands other than conversion and keep-on write leave state unchanged
// - only conversion commands enter measure
// - core states independent of serial-link states
// - watchdog expiry resets, releases open-drain output
`timescale 1ns/1ns
`default_nettype none
module mcp_core
  import mcp_pkg::*;
#(
  parameter logic [31:0] REFERENCE_READY_STATE_CYCLES = 32'(mcp_pkg::REFERENCE_READY_STATE_CYCLES_DEF),
  parameter logic [31:0] WDOG_CYCLES  = 32'(mcp_pkg::WDOG_CYCLES_DEF)
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic wake_detect,
  input  wire logic valid_cmd,
  input  wire logic conversion_cmd,
  input  wire logic write_config_group_a_cmd,
  input  wire logic keep_on_wdata,
  input  wire logic conversion_done,
  input  wire logic discharge_enable,
  input  wire logic discharge_expired,
  output logic      reference_on,
  output logic      converters_on,
  output logic      regulator_drive_on,
  output logic      link_enable,
  output logic      measure_start,
  output logic      reference_keep_on,
  output logic      watchdog_output_o,
  output logic      watchdog_output_oe,
  output logic      watchdog_reset,
  output mcp_pkg::mcp_state_t core_state
);
  import mcp_pkg::*;

  // ==========================================================
  // timers
  mcp_timer_if wdog_if ();
  mcp_timer_if refw_if ();

  mcp_timer #(.LENGTH(WDOG_CYCLES)) u_wdog (
    .clock (clock),
    .rst_b (rst_b),
    .tif   (wdog_if)
  );

  mcp_timer #(.LENGTH(REFERENCE_READY_STATE_CYCLES)) u_refw (
    .clock (clock),
    .rst_b (rst_b),
    .tif   (refw_if)
  );

  // ==========================================================
  // command decode
  mcp_state_t state;
  mcp_state_t next_state;
  logic       pend_measure;
  logic       next_pend_measure;
  logic       next_keep_on;
  logic       keep_write;
  logic       conv_ok;
  logic       wdog_expired;
  logic       timers_expired;
  logic       wdog_fire;
  logic       wdog_fire_q;

  assign keep_write     = valid_cmd && write_config_group_a_cmd;
  assign conv_ok        = valid_cmd && conversion_cmd;
  assign wdog_expired   = wdog_if.expired;
  assign timers_expired = wdog_expired && (!discharge_enable || discharge_expired);
  // rising expiry while awake; a command in that cycle restarts instead
  assign wdog_fire      = wdog_expired && !wdog_fire_q && (state != MCP_SLEEP) &&
                          !valid_cmd;

  // restart on any valid command while awake, or on wake
  assign wdog_if.load         = valid_cmd || (state == MCP_SLEEP && wake_detect);
  // watchdog treated as expired in sleep
  assign wdog_if.hold_expired = (state == MCP_SLEEP) && !wake_detect;
  assign refw_if.load         = (next_state == MCP_REF_WAIT) && (state != MCP_REF_WAIT);
  assign refw_if.hold_expired = 1'b0;

  // keep-on bit: host write, auto clear on watchdog expiry
  always_comb begin
    next_keep_on = reference_keep_on;
    if (keep_write) begin
      next_keep_on = keep_on_wdata;
    end else if (wdog_fire) begin
      next_keep_on = 1'b0;
    end
  end

  // ==========================================================
  // state machine
  always_comb begin
    next_state        = state;
    next_pend_measure = pend_measure;
    case (state)
      MCP_SLEEP: begin
        if (wake_detect) next_state = MCP_STANDBY;
      end
      MCP_STANDBY: begin
        if (conv_ok || (keep_write && keep_on_wdata)) begin
          next_state        = MCP_REF_WAIT;
          next_pend_measure = conv_ok;
        end else if (timers_expired && !valid_cmd) begin
          next_state = MCP_SLEEP;
        end
      end
      MCP_REF_WAIT: begin
        if (conv_ok) next_pend_measure = 1'b1;
        if (refw_if.expired) begin
          if (pend_measure || conv_ok) begin
            next_state = MCP_MEASURE;
          end else if (next_keep_on) begin
            next_state = MCP_REFERENCE_READY;
          end else begin
            next_state = MCP_STANDBY;
          end
          next_pend_measure = 1'b0;
        end
      end
      MCP_REFERENCE_READY: begin
        if (conv_ok) begin
          next_state = MCP_MEASURE;
        end else if (!next_keep_on) begin
          next_state = (wdog_fire && timers_expired) ? MCP_SLEEP : MCP_STANDBY;
        end
      end
      MCP_MEASURE: begin
        if (conversion_done) begin
          next_state = next_keep_on ? MCP_REFERENCE_READY : MCP_STANDBY;
        end
      end
      default: begin
        next_state        = MCP_SLEEP;
        next_pend_measure = 1'b0;
      end
    endcase
  end
  // commands other than conversion and keep-on write only restart the watchdog

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state             <= MCP_SLEEP;
      pend_measure      <= 1'b0;
      reference_keep_on <= 1'b0;
      wdog_fire_q       <= 1'b1;
    end else begin
      state             <= next_state;
      pend_measure      <= next_pend_measure;
      reference_keep_on <= next_keep_on;
      wdog_fire_q       <= wdog_expired;
    end
  end

  // ==========================================================
  // power and pin outputs, registered
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reference_on       <= 1'b0;
      converters_on      <= 1'b0;
      regulator_drive_on <= 1'b0;
      link_enable        <= 1'b0;
      measure_start      <= 1'b0;
      watchdog_reset     <= 1'b0;
      watchdog_output_oe <= 1'b0;
    end else begin
      reference_on       <= (next_state == MCP_REF_WAIT) ||
                            (next_state == MCP_REFERENCE_READY) ||
                            (next_state == MCP_MEASURE);
      converters_on      <= (next_state == MCP_MEASURE);
      regulator_drive_on <= (next_state != MCP_SLEEP);
      link_enable        <= (next_state != MCP_SLEEP);
      measure_start      <= (next_state == MCP_MEASURE) && (state != MCP_MEASURE);
      watchdog_reset     <= wdog_fire;
      // pull low from the reload edge on, release on expiry
      watchdog_output_oe <= (wdog_if.load && !wdog_if.hold_expired) ||
                            !wdog_if.expired;
    end
  end

  assign watchdog_output_o = 1'b0;
  assign core_state        = state;

endmodule : mcp_core
`default_nettype wire

//--- dv/mcp_core_asserts.sv
// Purpose: state and power relations of mcp_core
// Assumes: bench keeps the watchdog alive while a check runs
// Notes:   bound to every mcp_core
`timescale 1ns/1ns
`default_nettype none
module mcp_core_asserts
  import mcp_pkg::*;
(
  input wire logic                clock,
  input wire logic                rst_b,
  input wire logic                wake_detect,
  input wire logic                valid_cmd,
  input wire logic                conversion_cmd,
  input wire logic                write_config_group_a_cmd,
  input wire logic                conversion_done,
  input wire logic                reference_on,
  input wire logic                converters_on,
  input wire logic                regulator_drive_on,
  input wire logic                link_enable,
  input wire logic                measure_start,
  input wire logic                reference_keep_on,
  input wire logic                watchdog_output_oe,
  input wire mcp_pkg::mcp_state_t core_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire logic sb = core_state == MCP_STANDBY;
  wire logic rr = core_state == MCP_REFERENCE_READY;
  sequence s_conv;
    sb && valid_cmd && conversion_cmd;
  endsequence
  sequence s_wait;
    (core_state == MCP_REF_WAIT)[*8];
  endsequence
  // ====
  // checks
  a_sleep_quiet:
    assert property (core_state == MCP_SLEEP |-> !(reference_on | converters_on
      | regulator_drive_on | link_enable | watchdog_output_oe)) else $error("sleep output on");
  a_wake_up:
    assert property (core_state == MCP_SLEEP && wake_detect |=> sb) else $error("no wake");
  a_standby_off:
    assert property (sb |-> regulator_drive_on && !reference_on && !converters_on)
      else $error("standby power wrong");
  a_wait_first:
    assert property (s_conv |=> s_wait ##[1:40] core_state == MCP_MEASURE)
      else $error("reference wait wrong");
  a_ready_ref:
    assert property (rr |-> reference_on && !converters_on) else $error("ready power wrong");
  a_ready_go:
    assert property (rr && valid_cmd && conversion_cmd |=> core_state == MCP_MEASURE)
      else $error("ready did not measure");
  a_measure_pwr:
    assert property (core_state == MCP_MEASURE |-> reference_on && converters_on)
      else $error("measure power wrong");
  a_start_pulse:
    assert property ($rose(converters_on) |-> measure_start) else $error("no start pulse");
  a_done_exit:
    assert property (core_state == MCP_MEASURE && conversion_done |=> core_state ==
      (reference_keep_on ? MCP_REFERENCE_READY : MCP_STANDBY)) else $error("bad exit");
  a_other_hold:
    assert property (valid_cmd && !conversion_cmd && !write_config_group_a_cmd && (sb || rr)
      |=> $stable(core_state)) else $error("state moved");
endmodule : mcp_core_asserts
bind mcp_core mcp_core_asserts u_chk (.clock, .rst_b, .wake_detect, .valid_cmd,
  .conversion_cmd, .write_config_group_a_cmd, .conversion_done, .reference_on,
  .converters_on, .regulator_drive_on, .link_enable, .measure_start,
  .reference_keep_on, .watchdog_output_oe, .core_state);
`default_nettype wire

//--- dv/mcp_host_model.sv
// Purpose: host side issuing wake-up and command pulses
// Assumes: changes at the falling edge
// Notes:   qualifiers zero before the first command, inverted between commands after it
`timescale 1ns/1ns
`default_nettype none
module mcp_host_model (
  input  wire logic clock,
  output logic      wake_detect,
  output logic      valid_cmd,
  output logic      conversion_cmd,
  output logic      write_config_group_a_cmd,
  output logic      keep_on_wdata
);
  initial begin
    {wake_detect, valid_cmd, conversion_cmd, write_config_group_a_cmd, keep_on_wdata} = '0;
  end
  task automatic wake();
    @(negedge clock) wake_detect = 1'b1;
    @(negedge clock) wake_detect = 1'b0;
  endtask : wake
  task automatic cmd(input logic c, input logic w, input logic k);
    @(negedge clock);
    valid_cmd = 1'b1;
    conversion_cmd = c;
    write_config_group_a_cmd = w;
    keep_on_wdata = k;
    @(negedge clock);
    valid_cmd = 1'b0;
    {conversion_cmd, write_config_group_a_cmd, keep_on_wdata} = ~{c, w, k};
  endtask : cmd
endmodule : mcp_host_model
`default_nettype wire

//--- dv/mcp_core_bench.sv
// Purpose: self-checking bench of mcp_core
// Assumes: short reference wait and watchdog counts
// Notes:   expected power levels derived from state
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected %0t value mismatch", $time); end end
module mcp_core_bench;
  import mcp_pkg::*;
  localparam logic [31:0] RU = 32'h0000_0010;
  localparam logic [31:0] WD = 32'h0000_0040;
  logic clock, rst_b, conversion_done, discharge_enable, discharge_expired;
  logic reference_on, converters_on, regulator_drive_on, reference_keep_on, watchdog_output_oe;
  logic link_enable, watchdog_reset, watchdog_output_o;
  int n_wdog_rst = 0;
  wire logic wake_detect, valid_cmd, conversion_cmd, write_config_group_a_cmd, keep_on_wdata;
  mcp_state_t core_state;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h0000_0058;
  logic [31:0] r;
  mcp_host_model host (.clock, .wake_detect, .valid_cmd, .conversion_cmd,
    .write_config_group_a_cmd, .keep_on_wdata);
  mcp_core #(.REFERENCE_READY_STATE_CYCLES(RU), .WDOG_CYCLES(WD)) DUT (.clock, .rst_b, .wake_detect,
    .valid_cmd, .conversion_cmd, .write_config_group_a_cmd, .keep_on_wdata,
    .conversion_done, .discharge_enable, .discharge_expired, .reference_on, .converters_on,
    .regulator_drive_on, .link_enable, .measure_start(), .reference_keep_on,
    .watchdog_output_o, .watchdog_output_oe, .watchdog_reset, .core_state);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [3:0] pw(input mcp_state_t e);
    return {e != MCP_SLEEP && e != MCP_STANDBY, e == MCP_MEASURE, e != MCP_SLEEP,
            e != MCP_SLEEP};
  endfunction : pw
  task automatic go(input mcp_state_t e, input int n);
    for (int i = 0; i < n && core_state !== e; i++) @(negedge clock);
    `CHK(core_state, e)
    `CHK({reference_on, converters_on, regulator_drive_on, link_enable}, pw(e))
  endtask : go
  task automatic fin();
    @(negedge clock) conversion_done = 1'b1;
    @(negedge clock) conversion_done = 1'b0;
  endtask : fin
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // ====
  // clock, timeout, sequence
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      test_done();
    end
  end
  // one count per watchdog expiry while awake
  always @(negedge clock) begin
    if (watchdog_reset === 1'b1) n_wdog_rst++;
  end
  initial begin
    {rst_b, conversion_done, discharge_enable, discharge_expired} = '0;
    repeat (6) @(posedge clock);
    @(negedge clock) rst_b = 1'b1;
    go(MCP_SLEEP, 1);
    host.cmd(1'b1, 1'b0, 1'b0);
    go(MCP_SLEEP, 2);
    host.wake();
    go(MCP_STANDBY, 3);
    `CHK(watchdog_output_oe, 1'b1)
    `CHK(watchdog_output_o, 1'b0)
    repeat (4) begin
      r = rnd();
      repeat (r[2:1]) @(negedge clock);
      host.cmd(1'b0, 1'b0, r[0]);
      go(MCP_STANDBY, 1);
    end
    host.cmd(1'b1, 1'b0, 1'b0);
    go(MCP_REF_WAIT, 2);
    go(MCP_MEASURE, RU + 4);
    fin();
    go(MCP_STANDBY, 2);
    host.cmd(1'b0, 1'b1, 1'b1);
    go(MCP_REFERENCE_READY, RU + 4);
    host.cmd(1'b1, 1'b0, 1'b0);
    go(MCP_MEASURE, 1);
    fin();
    go(MCP_REFERENCE_READY, 2);
    host.cmd(1'b0, 1'b1, 1'b0);
    go(MCP_STANDBY, 2);
    host.cmd(1'b1, 1'b1, 1'b1);
    go(MCP_MEASURE, RU + 4);
    fin();
    go(MCP_REFERENCE_READY, 2);
    {discharge_enable, discharge_expired} = 2'b11;
    go(MCP_SLEEP, WD + 10);
    `CHK(reference_keep_on, 1'b0)
    host.wake();
    go(MCP_STANDBY, 3);
    discharge_expired = 1'b0;
    repeat (WD + 10) @(negedge clock);
    go(MCP_STANDBY, 1);
    `CHK(watchdog_output_oe, 1'b0)
    discharge_expired = 1'b1;
    go(MCP_SLEEP, 4);
    discharge_enable = 1'b0;
    discharge_expired = 1'b0;
    host.wake();
    go(MCP_STANDBY, 3);
    go(MCP_SLEEP, WD + 10);
    @(negedge clock);
    `CHK(n_wdog_rst, 3)
    test_done();
  end
endmodule : mcp_core_bench
`default_nettype wire
